// File: common/dss_defs.vh
// How it works
// - Raw pulses re-emitted centred in bit window.
// - Decoded NRZ data output on window clock.
// - Preamble means interval within 15 percent.
// - Gate low: high gain, crystal tracking.
// - Two-state: first bit, then low-gain data tracking.
// - Two-state: NRZ after 8 bits, data immediately.
// - Four-state: 8 preamble bits start high-gain tracking.
// - Four-state: 16 preamble bits enable both outputs.
// - Preamble lost before 16 returns to idle.
// - Preamble lost after 16 selects low gain.
// - Four-state: fill byte on data output while acquiring.
// - Early/late pair picks zero, one, two units.
// - Shift amount and bit rate size unit.
// - Bit rate is reference over coded divisor.
// - Reference clock sets window and shift timing.
// - Quarter-period alignment needs no trimming.
// - Select low four-state, high two-state.
// - NRZ and mark outputs float without gate.
// - Mark found high for one bit period.
// - Unit is multiple of 2/(7f), some illegal.
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH
`define DSS_PCLK_KHZ 20000
`define DSS_REF_KHZ 8000
`define DSS_PCLK_PS 50000
`define DSS_XUNIT_PS (2000000000 / (7 * `DSS_REF_KHZ))
`define DSS_CYC(d) ((d) * `DSS_PCLK_KHZ / `DSS_REF_KHZ)
`define DSS_WR_BASE_NS 100
`define DSS_WR_BASE_CYC ((`DSS_WR_BASE_NS * 1000 + `DSS_PCLK_PS - 1) / `DSS_PCLK_PS)
`define DSS_WR_PULSE_CYC 4'h2
`define DSS_ADDR_CFG 4'h0
`define DSS_ADDR_STAT 4'h4
`define DSS_CFG_RESET 7'h00
`define DSS_CFG_ENC 0
`define DSS_CFG_RATE_LO 1
`define DSS_CFG_RATE_HI 2
`define DSS_CFG_AMT_LO 3
`define DSS_CFG_AMT_HI 5
`define DSS_CFG_MODE 6
`define DSS_PRE_LO_PCT 7'h55
`define DSS_PRE_HI_PCT 7'h73
`define DSS_RUN_EIGHT 5'h08
`define DSS_RUN_SIXTEEN 5'h10
`define DSS_NRZ_HOLD_BITS 4'h8
`define DSS_FILL_MFM 8'h4e
`define DSS_FILL_FM 8'hff
`define DSS_MARK_PATTERN 8'ha1
`endif

// File: core/dss_sequencer.v
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dss_defs.vh"
module dss_sequencer (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire [3:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Drive and controller pins.
  input  wire        read_gate,
  input  wire        raw_read_data,
  input  wire        write_data_in,
  input  wire        shift_early,
  input  wire        shift_late,
  output reg         sep_data_r,
  output reg         read_clock_r,
  output reg         nrz_data_r,
  output reg         nrz_oe_n_r,
  output reg         address_mark_found_r,
  output reg         amf_oe_n_r,
  output reg         write_data_out_r,
  // Loop steering and status.
  output reg         loop_high_gain_r,
  output reg         loop_track_data_r,
  output reg         test_mode_r
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ACQ  = 5'h02;
  localparam [4:0] ST_HIGH = 5'h04;
  localparam [4:0] ST_LOCK = 5'h08;
  localparam [4:0] ST_LOW  = 5'h10;
  localparam integer CYC64_I = `DSS_CYC(64);
  localparam integer CYC32_I = `DSS_CYC(32);
  localparam integer CYC16_I = `DSS_CYC(16);
  localparam integer CYC8_I  = `DSS_CYC(8);
  localparam [8:0] CYC64 = CYC64_I[8:0];
  localparam [8:0] CYC32 = CYC32_I[8:0];
  localparam [8:0] CYC16 = CYC16_I[8:0];
  localparam [8:0] CYC8  = CYC8_I[8:0];

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  reg  [4:0] s1_r;
  reg  [4:0] s2_r;
  reg        raw_d_r;
  reg        wr_d_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 5'h00;
      s2_r    <= 5'h00;
      raw_d_r <= 1'b0;
      wr_d_r  <= 1'b0;
    end else begin
      s1_r    <= {shift_late, shift_early, write_data_in, raw_read_data, read_gate};
      s2_r    <= s1_r;
      raw_d_r <= s2_r[1];
      wr_d_r  <= s2_r[2];
    end
  end
  wire gate   = s2_r[0];
  wire pulse  = s2_r[1] & ~raw_d_r;
  wire wr_rise = s2_r[2] & ~wr_d_r;

  // ---------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------
  reg  [6:0]  cfg_r;
  reg  [4:0]  state_r;
  reg  [4:0]  run_r;
  wire        setup = psel & ~penable;
  wire        hit_cfg = (paddr == `DSS_ADDR_CFG);
  wire        hit_stat = (paddr == `DSS_ADDR_STAT);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= `DSS_CFG_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_cfg & ~hit_stat;
      if (setup & hit_cfg)
        prdata <= {25'h000_0000, cfg_r};
      else if (setup & hit_stat)
        prdata <= {19'h0_0000, test_mode_r, loop_track_data_r, loop_high_gain_r,
                   run_r, state_r};
      else
        prdata <= 32'h0000_0000;
      if (psel & penable & pready & pwrite & hit_cfg)
        cfg_r <= pwdata[6:0];
    end
  end
  wire       enc   = cfg_r[`DSS_CFG_ENC];
  wire [1:0] rate  = cfg_r[`DSS_CFG_RATE_HI:`DSS_CFG_RATE_LO];
  wire [2:0] amt   = cfg_r[`DSS_CFG_AMT_HI:`DSS_CFG_AMT_LO];
  wire       two_st = cfg_r[`DSS_CFG_MODE];

  // ---------------------------------------------------------------
  // Bit rate and data window.
  // ---------------------------------------------------------------
  reg [8:0] bit_cyc;
  always @* begin
    case ({rate, enc})
      3'b000:          bit_cyc = CYC64;
      3'b001, 3'b010:  bit_cyc = CYC32;
      3'b011, 3'b100:  bit_cyc = CYC16;
      default:         bit_cyc = CYC8;
    endcase
  end
  wire [7:0] cell_cyc = bit_cyc[8:1];
  wire [7:0] quarter  = {2'b00, cell_cyc[7:2]};
  wire [7:0] half     = {1'b0, cell_cyc[7:1]};
  reg  [7:0] phase_r;
  reg        cell_hit_r;
  wire       track = loop_track_data_r;
  wire       cell_end = (phase_r >= cell_cyc - 8'h01);
  reg  [7:0] phase_nxt;
  // The first data bit of a two-state read also snaps the window, so it starts centred.
  // Holding is skipped at the end of a cell, which would toggle the read clock twice.
  always @* begin
    phase_nxt = cell_end ? 8'h00 : phase_r + 8'h01;
    if (pulse & ((track & loop_high_gain_r) | (two_st & gate & (state_r == ST_ACQ))))
      phase_nxt = quarter;
    else if (pulse & track & (phase_r < quarter))
      phase_nxt = phase_r + 8'h02;
    else if (pulse & track & (phase_r > quarter) & ~cell_end)
      phase_nxt = phase_r;
  end

  // ---------------------------------------------------------------
  // Preamble detector.
  // ---------------------------------------------------------------
  reg  [8:0]  ivl_r;
  wire [15:0] ivl_pct = ivl_r * 7'h64;
  wire [15:0] lo_lim = bit_cyc * `DSS_PRE_LO_PCT;
  wire [15:0] hi_lim = bit_cyc * `DSS_PRE_HI_PCT;
  wire        in_band = (ivl_pct >= lo_lim) & (ivl_pct <= hi_lim);
  wire        det_on = gate & ~two_st;
  wire        pre_fail = det_on & ((pulse & ~in_band) | (ivl_pct > hi_lim));
  wire        preamble_eight_seen = (run_r >= `DSS_RUN_EIGHT);
  wire        preamble_sixteen_seen = (run_r >= `DSS_RUN_SIXTEEN);

  // ---------------------------------------------------------------
  // Acquisition sequence.
  // ---------------------------------------------------------------
  reg [4:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (gate) state_nxt = ST_ACQ;
      ST_ACQ: begin
        if (two_st & pulse)
          state_nxt = ST_LOW;
        else if (~two_st & preamble_eight_seen & ~pre_fail)
          state_nxt = ST_HIGH;
      end
      ST_HIGH: begin
        if (pre_fail)
          state_nxt = ST_IDLE;
        else if (preamble_sixteen_seen)
          state_nxt = ST_LOCK;
      end
      ST_LOCK: if (pre_fail) state_nxt = ST_LOW;
      ST_LOW:  state_nxt = ST_LOW;
      default: state_nxt = ST_IDLE;
    endcase
    if (!gate)
      state_nxt = ST_IDLE;
  end
  wire st_low = state_nxt == ST_LOW;
  wire st_track = (state_nxt == ST_HIGH) | (state_nxt == ST_LOCK) | st_low;

  // ---------------------------------------------------------------
  // Read path: window, data, NRZ, fill and address mark.
  // ---------------------------------------------------------------
  reg  [2:0] fill_idx_r;
  reg  [3:0] nbits_r;
  reg  [7:0] shreg_r;
  reg  [8:0] amf_cnt_r;
  wire       data_cell = read_clock_r;
  wire       filling = ~two_st & ((state_r == ST_ACQ) | (state_r == ST_HIGH));
  wire       out_on = two_st ? (state_r == ST_LOW)
                             : ((state_r == ST_LOCK) | (state_r == ST_LOW));
  wire       nrz_on = out_on & (~two_st | (nbits_r >= `DSS_NRZ_HOLD_BITS));
  wire [7:0] fill = enc ? `DSS_FILL_MFM : `DSS_FILL_FM;
  wire       nrz_bit = cell_hit_r | pulse;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      run_r <= 5'h00;
      ivl_r <= 9'h000;
      phase_r <= 8'h00;
      cell_hit_r <= 1'b0;
      read_clock_r <= 1'b0;
      sep_data_r <= 1'b0;
      nrz_data_r <= 1'b0;
      nrz_oe_n_r <= 1'b1;
      amf_oe_n_r <= 1'b1;
      address_mark_found_r <= 1'b0;
      fill_idx_r <= 3'h7;
      nbits_r <= 4'h0;
      shreg_r <= 8'h00;
      amf_cnt_r <= 9'h000;
      loop_high_gain_r <= 1'b1;
      loop_track_data_r <= 1'b0;
      test_mode_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      loop_high_gain_r <= ~st_low;
      loop_track_data_r <= st_track;
      test_mode_r <= (rate == 2'b11);
      phase_r <= phase_nxt;
      ivl_r <= pulse ? 9'h000 : (ivl_r == 9'h1ff ? ivl_r : ivl_r + 9'h001);
      if (!gate | pre_fail)
        run_r <= 5'h00;
      else if (det_on & pulse & ~preamble_sixteen_seen)
        run_r <= run_r + 5'h01;
      nrz_oe_n_r <= ~gate;
      amf_oe_n_r <= ~gate;
      if (cell_end) begin
        read_clock_r <= ~read_clock_r;
        cell_hit_r <= 1'b0;
      end else if (pulse) begin
        cell_hit_r <= 1'b1;
      end
      // A window held at its centre waits one clock, so the pulse is not emitted twice.
      if ((phase_r == half) & (phase_nxt != half))
        sep_data_r <= out_on ? cell_hit_r : (filling & data_cell & fill[fill_idx_r]);
      else
        sep_data_r <= 1'b0;
      if (cell_end & data_cell & filling)
        fill_idx_r <= fill_idx_r - 3'h1;
      else if (!filling)
        fill_idx_r <= 3'h7;
      if (cell_end & data_cell) begin
        nrz_data_r <= nrz_on & nrz_bit;
        shreg_r <= {shreg_r[6:0], nrz_bit};
        if (out_on & (nbits_r != 4'hf))
          nbits_r <= nbits_r + 4'h1;
      end
      if (!gate)
        nbits_r <= 4'h0;
      if (amf_cnt_r != 9'h000) begin
        amf_cnt_r <= amf_cnt_r - 9'h001;
        address_mark_found_r <= 1'b1;
      end else if (cell_end & data_cell & nrz_on
                   & ({shreg_r[6:0], nrz_bit} == `DSS_MARK_PATTERN)) begin
        amf_cnt_r <= bit_cyc - 9'h001;
        address_mark_found_r <= 1'b1;
      end else begin
        address_mark_found_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write shift.
  // ---------------------------------------------------------------
  reg [3:0] mult;
  always @* begin
    mult = {1'b0, amt};
    if (rate == 2'b00) begin
      case (amt)
        3'h1: mult = 4'h3;
        3'h2: mult = 4'h4;
        3'h3: mult = 4'h5;
        3'h4: mult = 4'h6;
        3'h5: mult = 4'h7;
        3'h6: mult = 4'h9;
        3'h7: mult = 4'hb;
        default: mult = 4'h0;
      endcase
    end else if ((rate == 2'b10) & (amt[2:1] == 2'b11)) begin
      mult = 4'h0;
    end
  end
  reg  [1:0]  units;
  always @* begin
    case ({s2_r[3], s2_r[4]})
      2'b00:   units = 2'h1;
      2'b01:   units = 2'h2;
      default: units = 2'h0;
    endcase
  end
  wire [31:0] wr_ps  = units * mult * `DSS_XUNIT_PS;
  wire [31:0] wr_cyc = `DSS_WR_BASE_CYC + wr_ps / `DSS_PCLK_PS;
  wire        wr_bad = s2_r[3] & s2_r[4];
  reg  [7:0]  wd_cnt_r;
  reg         wd_pend_r;
  reg  [3:0]  wd_len_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= 8'h00;
      wd_pend_r <= 1'b0;
      wd_len_r <= 4'h0;
      write_data_out_r <= 1'b0;
    end else begin
      if (wr_rise & ~wr_bad) begin
        wd_cnt_r <= wr_cyc[7:0];
        wd_pend_r <= 1'b1;
      end else if (wd_pend_r & (wd_cnt_r == 8'h00)) begin
        wd_pend_r <= 1'b0;
        wd_len_r <= `DSS_WR_PULSE_CYC;
      end else if (wd_pend_r) begin
        wd_cnt_r <= wd_cnt_r - 8'h01;
      end
      if (!(wd_pend_r & (wd_cnt_r == 8'h00)) & (wd_len_r != 4'h0))
        wd_len_r <= wd_len_r - 4'h1;
      write_data_out_r <= (wd_len_r != 4'h0);
    end
  end
endmodule
`default_nettype wire

// File: tb/dss_sequencer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "dss_defs.vh"
module dss_sequencer_monitor (
  // Clock, reset and bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [3:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins.
  input wire logic        read_gate,
  input wire logic        shift_early,
  input wire logic        shift_late,
  input wire logic        sep_data_r,
  input wire logic        nrz_oe_n_r,
  input wire logic        amf_oe_n_r,
  input wire logic        write_data_out_r,
  input wire logic        loop_high_gain_r,
  input wire logic        loop_track_data_r,
  input wire logic        test_mode_r
);
  logic [5:0] both_cnt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // -------------------------------------------------------------------
  // Counts clocks with both shift pins high, longest write delay covered.
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      both_cnt <= 6'h00;
    else if (shift_early && shift_late)
      both_cnt <= (both_cnt == 6'h3f) ? both_cnt : both_cnt + 6'h01;
    else
      both_cnt <= 6'h00;
  end

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  apb_once_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  apb_unmapped_a: assert property (psel && !penable && paddr != 4'h0 && paddr != 4'h4
    |=> pready && pslverr) else $error("unmapped not refused");
  gate_float_a: assert property (!read_gate [*5] |-> nrz_oe_n_r && amf_oe_n_r)
    else $error("outputs driven without gate");
  idle_gain_a: assert property (!read_gate [*5] |-> loop_high_gain_r && !loop_track_data_r)
    else $error("loop not on crystal");
  low_track_a: assert property (!loop_high_gain_r |-> loop_track_data_r)
    else $error("low gain without data");
  sep_pulse_a: assert property (sep_data_r |=> !sep_data_r)
    else $error("data pulse too wide");
  wr_width_a: assert property ($rose(write_data_out_r) |=> write_data_out_r ##1 !write_data_out_r)
    else $error("write pulse width");
  wr_drop_a: assert property (both_cnt >= 6'h28 |-> !write_data_out_r)
    else $error("illegal shift pair written");
  rate_test_a: assert property (psel && penable && pready && pwrite && paddr == `DSS_ADDR_CFG
    |-> ##2 test_mode_r == ($past(pwdata[2:1], 2) == 2'b11)) else $error("test mode flag");

  cover property (sep_data_r);
  cover property ($fell(loop_high_gain_r));
  cover property ($rose(write_data_out_r));
  cover property (pslverr);
endmodule

bind dss_sequencer dss_sequencer_monitor chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .read_gate(read_gate), .shift_early(shift_early),
  .shift_late(shift_late), .sep_data_r(sep_data_r), .nrz_oe_n_r(nrz_oe_n_r),
  .amf_oe_n_r(amf_oe_n_r), .write_data_out_r(write_data_out_r),
  .loop_high_gain_r(loop_high_gain_r), .loop_track_data_r(loop_track_data_r),
  .test_mode_r(test_mode_r));
`default_nettype wire

// File: tb/dss_disk_model.sv
`timescale 1ns/1ns
`default_nettype none
module dss_disk_model (
  // Clock.
  input  wire logic pclk,
  // Recovered read clock, high during data cells.
  input  wire logic read_clock,
  // Raw pulses towards the separator.
  output var logic  raw_read_data
);
  initial raw_read_data = 1'b0;

  // Pulses are two clocks wide so the input synchroniser cannot miss them.
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      raw_read_data <= 1'b1;
      repeat (2) @(posedge pclk);
      raw_read_data <= 1'b0;
      repeat (gap - 3) @(posedge pclk);
    end
  endtask

  // Places a pulse early in each data cell whose bit is set, most significant bit first.
  task automatic cells(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge read_clock);
      repeat (6) @(posedge pclk);
      raw_read_data <= v[i];
      repeat (2) @(posedge pclk);
      raw_read_data <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_disk_data_separator_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "dss_defs.vh"
module tb_disk_data_separator_sequencer;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        read_gate = 1'b0, write_data_in = 1'b0, shift_early = 1'b0, shift_late = 1'b0;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, er, raw_read_data, sep_data_r, read_clock_r, nrz_data_r;
  logic        nrz_oe_n_r, address_mark_found_r, amf_oe_n_r, write_data_out_r;
  logic        loop_high_gain_r, loop_track_data_r, test_mode_r;
  int          error_cnt = 0, checks_done = 0;

  always #25 pclk = ~pclk;

  dss_sequencer uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .read_gate(read_gate), .raw_read_data(raw_read_data),
    .write_data_in(write_data_in), .shift_early(shift_early), .shift_late(shift_late),
    .sep_data_r(sep_data_r), .read_clock_r(read_clock_r), .nrz_data_r(nrz_data_r),
    .nrz_oe_n_r(nrz_oe_n_r), .address_mark_found_r(address_mark_found_r),
    .amf_oe_n_r(amf_oe_n_r), .write_data_out_r(write_data_out_r),
    .loop_high_gain_r(loop_high_gain_r), .loop_track_data_r(loop_track_data_r),
    .test_mode_r(test_mode_r));
  dss_disk_model disk (.pclk(pclk), .read_clock(read_clock_r), .raw_read_data(raw_read_data));

  // -------------------------------------------------------------------
  // Shared tasks.
  // -------------------------------------------------------------------
  task automatic ck(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [6:0] v);
    apb(1'b1, `DSS_ADDR_CFG, {25'h000_0000, v});
  endtask

  task automatic gate(input logic g);
    @(posedge pclk);
    read_gate <= g;
    repeat (6) @(posedge pclk);
  endtask

  task automatic per(output int p);
    time t0;
    repeat (2) @(posedge read_clock_r);
    t0 = $time;
    @(posedge read_clock_r);
    p = int'(($time - t0) / 50);
  endtask

  task automatic wpulse(input logic [1:0] el, output int d);
    @(posedge pclk);
    shift_early <= el[1];
    shift_late <= el[0];
    repeat (4) @(posedge pclk);
    write_data_in <= 1'b1;
    d = -1;
    for (int i = 0; i < 60 && d < 0; i++) begin
      @(posedge pclk);
      if (i == 1)
        write_data_in <= 1'b0;
      if (write_data_out_r === 1'b1)
        d = i;
    end
  endtask

  task conclude;
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Scenarios.
  // -------------------------------------------------------------------
  task automatic t_reset;
    ck(nrz_oe_n_r === 1'b1 && amf_oe_n_r === 1'b1, "float at reset");
    ck(loop_high_gain_r === 1'b1 && loop_track_data_r === 1'b0, "idle loop");
    apb(1'b1, 4'h8, 32'h0000_007f);
    ck(er === 1'b1, "unmapped write refused");
    apb(1'b1, `DSS_ADDR_STAT, 32'h0000_007f);
    apb(1'b0, `DSS_ADDR_CFG, 32'h0000_0000);
    ck(rd === 32'h0000_0000, "cfg reset value");
    apb(1'b0, `DSS_ADDR_STAT, 32'h0000_0000);
    ck(rd[9:0] === 10'h001, "idle, run cleared");
    apb(1'b0, 4'h8, 32'h0000_0000);
    ck(er === 1'b1 && rd === 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_rates;
    int p;
    int exp_p [6] = '{160, 80, 80, 40, 40, 20};
    for (int c = 0; c < 6; c++) begin
      cfg(c[6:0]);
      per(p);
      ck(p == exp_p[c], "bit period");
      ck(test_mode_r === 1'b0, "no test mode");
    end
    cfg(7'h06);
    repeat (3) @(posedge pclk);
    ck(test_mode_r === 1'b1, "test mode");
    cfg(7'h00);
  endtask

  task automatic t_fill;
    int n, z;
    for (int e = 0; e < 2; e++) begin
      cfg(e ? 7'h01 : 7'h02);
      gate(1'b1);
      repeat (100) @(posedge pclk);
      n = 0;
      z = 0;
      repeat (640) begin
        @(posedge pclk);
        n += (sep_data_r === 1'b1);
        z += (nrz_data_r !== 1'b0);
      end
      ck(n == (e ? 4 : 8) && z == 0, "fill byte");
      gate(1'b0);
    end
  endtask

  task automatic t_four;
    cfg(7'h01);
    gate(1'b1);
    disk.burst(11, 80);
    ck(loop_track_data_r === 1'b1 && loop_high_gain_r === 1'b1, "fast track");
    ck(nrz_data_r === 1'b0, "nrz low acquiring");
    repeat (200) @(posedge pclk);
    ck(loop_track_data_r === 1'b0 && loop_high_gain_r === 1'b1, "back to crystal");
    disk.burst(20, 80);
    apb(1'b0, `DSS_ADDR_STAT, 32'h0000_0000);
    ck(rd[3] === 1'b1 && nrz_oe_n_r === 1'b0, "locked");
    repeat (200) @(posedge pclk);
    ck(loop_high_gain_r === 1'b0 && loop_track_data_r === 1'b1, "low gain");
    gate(1'b0);
    ck(loop_high_gain_r === 1'b1 && nrz_oe_n_r === 1'b1, "gate off");
    apb(1'b0, `DSS_ADDR_STAT, 32'h0000_0000);
    ck(rd[9:0] === 10'h001, "run cleared");
  endtask

  task automatic t_two;
    int n, z;
    cfg(7'h41);
    gate(1'b1);
    repeat (100) @(posedge pclk);
    ck(loop_track_data_r === 1'b0 && loop_high_gain_r === 1'b1, "wait first bit");
    n = 0;
    z = 0;
    fork
      disk.burst(7, 80);
      repeat (560) begin
        @(posedge pclk);
        n += (sep_data_r === 1'b1);
        z += (nrz_data_r !== 1'b0);
      end
    join
    ck(n >= 6 && z == 0, "data on, nrz held");
    ck(loop_track_data_r === 1'b1 && loop_high_gain_r === 1'b0, "slow track");
    gate(1'b0);
  endtask

  task automatic t_mark;
    int n;
    cfg(7'h41);
    gate(1'b1);
    disk.cells(16'h0fff, 12);
    @(negedge read_clock_r);
    @(posedge pclk);
    ck(nrz_data_r === 1'b1 && nrz_oe_n_r === 1'b0, "nrz data");
    disk.cells(16'h00a1, 8);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      n += (address_mark_found_r === 1'b1);
    end
    ck(n == 80 && amf_oe_n_r === 1'b0, "mark found one bit");
    gate(1'b0);
  endtask

  task automatic t_write;
    int d [3];
    logic [1:0] el [3] = '{2'b10, 2'b00, 2'b01};
    for (int a = 0; a < 2; a++) begin
      cfg(a ? 7'h38 : 7'h00);
      for (int k = 0; k < 3; k++)
        wpulse(el[k], d[k]);
      if (a)
        ck(d[1] - d[0] inside {[7:8]} && d[2] - d[1] inside {[7:9]}, "unit steps");
      else
        ck(d[0] >= 0 && d[0] == d[1] && d[1] == d[2], "zero amount");
    end
    wpulse(2'b11, d[0]);
    ck(d[0] < 0, "illegal pair dropped");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rates;
    t_fill;
    t_four;
    t_two;
    t_mark;
    t_write;
    conclude;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    conclude;
  end
endmodule
`default_nettype wire
